// file: bld_pkg.sv
// Package of encodings, constants, reset values and state names for the decode block.
package bld_pkg;
  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [4:0] BLD_OP_LDM = 5'h19;
  localparam logic [4:0] BLD_OP_LDR_IMM = 5'h0D;
  localparam logic [4:0] BLD_OP_LDR_SP = 5'h13;
  localparam logic [4:0] BLD_OP_LDR_PC = 5'h09;
  localparam logic [15:0] BLD_SYNC_HI = 16'hF3BF;
  localparam logic [11:0] BLD_SYNC_LO_TOP = 12'h8F6;
  localparam logic [3:0] BLD_FULL_SYSTEM_OPTION = 4'hF;
  localparam logic [3:0] BLD_SP_INDEX = 4'hD;
  localparam logic [1:0] BLD_WORD_ALIGN_ZERO = 2'h0;
  localparam logic [7:0] BLD_MASK_PREFIX = 8'h00;
  localparam logic [31:0] BLD_WORD_BYTES = 32'h00000004;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] BLD_RST_WORD = 32'h00000000;
  localparam logic [3:0] BLD_RST_REG = 4'h0;
  localparam logic [15:0] BLD_RST_MASK = 16'h0000;
  typedef enum logic [2:0] {
    BLD_IDLE, BLD_LOAD_REQ, BLD_LOAD_WAIT, BLD_SYNC_DRAIN, BLD_DONE
  } bld_state_e;
endpackage

// file: bld_lowest_bit.sv
// Finder of the lowest set bit of a register mask.
`timescale 1ns/10ps
module bld_lowest_bit #(
  parameter int WIDTH = 16
) (
  // Mask in
  input wire logic [WIDTH-1:0] mask,
  // Result
  output logic found,
  output logic [$clog2(WIDTH)-1:0] index
);
  initial begin
    if (WIDTH < 2) begin
      $error("bld_lowest_bit needs at least two bits");
    end
  end

  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        found = 1'b1;
        index = i[$clog2(WIDTH)-1:0];
      end
    end
  end
endmodule // bld_lowest_bit

// file: bld_barrier_and_load_decode.sv
// Decode and execute of sync barrier, load multiple and load word forms.
// Notes on behaviour
// - Sync barrier flushes pipeline, refetches after completion.
// - Earlier context changes visible to refetched instructions.
// - Later branches predicted with post-barrier context.
// - All barrier options execute as full system.
// - Load multiple: base field, zero-prefixed mask.
// - Empty load multiple mask is unpredictable.
// - Lowest register loads from lowest address.
// - Write back base only when not in mask.
// - Short offset is immediate times four.
// - Stack form uses register 13, long offset.
// - Word load at base plus offset, no write-back.
// - PC form uses word-aligned PC plus offset.
// - PC form: destination field, offset always added.
`timescale 1ns/10ps
module bld_barrier_and_load_decode
  import bld_pkg::*;
#(
  parameter int NREG = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [31:0] issue_instr,
  input wire logic issue_is_wide,
  input wire logic [31:0] issue_pc,
  input wire logic cond_pass,
  // Register file read
  output logic [3:0] rf_rd_idx,
  input wire logic [31:0] rf_rd_data,
  // Register file write
  output logic rf_wr_en,
  output logic [3:0] rf_wr_idx,
  output logic [31:0] rf_wr_data,
  // Memory load port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Pipeline control
  input wire logic ctx_ops_done,
  output logic pipe_flush,
  output logic [31:0] refetch_pc,
  output logic predictor_resync,
  // Status
  output logic retire,
  output logic unpredictable
);
  import bld_pkg::*;

  initial begin
    if (NREG != 16) begin
      $error("bld_barrier_and_load_decode serves sixteen registers only");
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [15:0] hw;
  logic [4:0] major;
  logic is_sync, is_ldm, is_ldr_imm, is_ldr_sp, is_ldr_pc;
  logic [15:0] dec_mask;
  logic [31:0] dec_off;
  logic [3:0] dec_dst, dec_base;
  logic [3:0] dec_option;

  function automatic logic [31:0] word_offset(input logic [7:0] imm);
    word_offset = {22'h000000, imm, BLD_WORD_ALIGN_ZERO};
  endfunction

  always_comb begin
    hw = issue_instr[15:0];
    major = hw[15:11];
    is_sync = issue_is_wide && issue_instr[31:16] == BLD_SYNC_HI &&
              issue_instr[15:4] == BLD_SYNC_LO_TOP;
    is_ldm = !issue_is_wide && major == BLD_OP_LDM;
    is_ldr_imm = !issue_is_wide && major == BLD_OP_LDR_IMM;
    is_ldr_sp = !issue_is_wide && major == BLD_OP_LDR_SP;
    is_ldr_pc = !issue_is_wide && major == BLD_OP_LDR_PC;
    dec_option = issue_instr[3:0];
    dec_mask = {BLD_MASK_PREFIX, hw[7:0]};
    dec_base = {1'b0, hw[10:8]};
    dec_dst = {1'b0, hw[2:0]};
    dec_off = word_offset({3'h0, hw[10:6]});
    if (is_ldr_imm) begin
      dec_base = {1'b0, hw[5:3]};
    end
    if (is_ldr_sp || is_ldr_pc) begin
      dec_base = BLD_SP_INDEX;
      dec_dst = {1'b0, hw[10:8]};
      dec_off = word_offset(hw[7:0]);
    end
  end

  // ****************************************************************
  // Execute state
  // ****************************************************************
  bld_state_e state_ff, nxt_state_ff;
  logic [31:0] addr_ff, nxt_addr_ff;
  logic [15:0] mask_ff, nxt_mask_ff;
  logic [3:0] base_ff, nxt_base_ff;
  logic [3:0] dst_ff, nxt_dst_ff;
  logic multi_ff, nxt_multi_ff;
  logic wback_ff, nxt_wback_ff;
  logic [31:0] next_pc_ff, nxt_next_pc_ff;
  logic wr_en_ff, nxt_wr_en_ff;
  logic [3:0] wr_idx_ff, nxt_wr_idx_ff;
  logic [31:0] wr_data_ff, nxt_wr_data_ff;
  logic flush_ff, nxt_flush_ff;
  logic retire_ff, nxt_retire_ff;
  logic unpred_ff, nxt_unpred_ff;
  logic [3:0] low_idx;

  // An empty mask never reaches the load states, so the found flag is idle.
  bld_lowest_bit #(.WIDTH(NREG)) u_lowest (
    .mask(mask_ff),
    .found(),
    .index(low_idx)
  );

  assign issue_ready = state_ff == BLD_IDLE;
  assign rf_rd_idx = dec_base;
  assign mem_req = state_ff == BLD_LOAD_REQ || state_ff == BLD_LOAD_WAIT;
  assign mem_addr = addr_ff;
  assign rf_wr_en = wr_en_ff;
  assign rf_wr_idx = wr_idx_ff;
  assign rf_wr_data = wr_data_ff;
  assign pipe_flush = flush_ff;
  assign predictor_resync = flush_ff;
  assign refetch_pc = next_pc_ff;
  assign retire = retire_ff;
  assign unpredictable = unpred_ff;

  always_comb begin
    nxt_state_ff = state_ff;
    nxt_addr_ff = addr_ff;
    nxt_mask_ff = mask_ff;
    nxt_base_ff = base_ff;
    nxt_dst_ff = dst_ff;
    nxt_multi_ff = multi_ff;
    nxt_wback_ff = wback_ff;
    nxt_next_pc_ff = next_pc_ff;
    nxt_wr_en_ff = 1'b0;
    nxt_wr_idx_ff = wr_idx_ff;
    nxt_wr_data_ff = wr_data_ff;
    nxt_flush_ff = 1'b0;
    nxt_retire_ff = 1'b0;
    nxt_unpred_ff = 1'b0;
    unique case (state_ff)
      BLD_IDLE: begin
        if (issue_valid) begin
          nxt_next_pc_ff = issue_pc + (issue_is_wide ? BLD_WORD_BYTES :
                           32'h00000002);
          nxt_base_ff = dec_base;
          nxt_dst_ff = dec_dst;
          nxt_multi_ff = is_ldm;
          nxt_mask_ff = dec_mask;
          nxt_wback_ff = !dec_mask[dec_base];
          if (!cond_pass) begin
            nxt_retire_ff = 1'b1;
          end else if (is_sync) begin
            // Any option value is a full barrier; reserved ones too.
            nxt_state_ff = BLD_SYNC_DRAIN;
          end else if (is_ldm && dec_mask == BLD_RST_MASK) begin
            nxt_unpred_ff = 1'b1;
            nxt_retire_ff = 1'b1;
          end else if (is_ldm) begin
            nxt_addr_ff = rf_rd_data;
            nxt_state_ff = BLD_LOAD_REQ;
          end else if (is_ldr_pc) begin
            // The read PC is four ahead of this halfword.
            nxt_addr_ff = ((issue_pc + BLD_WORD_BYTES) & 32'hFFFFFFFC) +
                          dec_off;
            nxt_state_ff = BLD_LOAD_REQ;
          end else if (is_ldr_imm || is_ldr_sp) begin
            nxt_addr_ff = rf_rd_data + dec_off;
            nxt_state_ff = BLD_LOAD_REQ;
          end else begin
            nxt_retire_ff = 1'b1;
          end
        end
      end
      BLD_LOAD_REQ, BLD_LOAD_WAIT: begin
        nxt_state_ff = BLD_LOAD_WAIT;
        if (mem_ack) begin
          nxt_wr_en_ff = 1'b1;
          nxt_wr_data_ff = mem_rdata;
          if (multi_ff) begin
            nxt_wr_idx_ff = low_idx;
            nxt_mask_ff = mask_ff & ~(16'h0001 << low_idx);
            nxt_addr_ff = addr_ff + BLD_WORD_BYTES;
            nxt_state_ff = BLD_LOAD_REQ;
            if ((mask_ff & ~(16'h0001 << low_idx)) == BLD_RST_MASK) begin
              nxt_state_ff = wback_ff ? BLD_DONE : BLD_IDLE;
              nxt_retire_ff = !wback_ff;
            end
          end else begin
            nxt_wr_idx_ff = dst_ff;
            nxt_state_ff = BLD_IDLE;
            nxt_retire_ff = 1'b1;
          end
        end
      end
      BLD_DONE: begin
        nxt_wr_en_ff = 1'b1;
        nxt_wr_idx_ff = base_ff;
        nxt_wr_data_ff = addr_ff;
        nxt_retire_ff = 1'b1;
        nxt_state_ff = BLD_IDLE;
      end
      BLD_SYNC_DRAIN: begin
        // Waiting here keeps fetch stalled until older context work lands.
        if (ctx_ops_done) begin
          nxt_flush_ff = 1'b1;
          nxt_retire_ff = 1'b1;
          nxt_state_ff = BLD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= BLD_IDLE;
      addr_ff <= BLD_RST_WORD;
      mask_ff <= BLD_RST_MASK;
      base_ff <= BLD_RST_REG;
      dst_ff <= BLD_RST_REG;
      multi_ff <= 1'b0;
      wback_ff <= 1'b0;
      next_pc_ff <= BLD_RST_WORD;
      wr_en_ff <= 1'b0;
      wr_idx_ff <= BLD_RST_REG;
      wr_data_ff <= BLD_RST_WORD;
      flush_ff <= 1'b0;
      retire_ff <= 1'b0;
      unpred_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state_ff;
      addr_ff <= nxt_addr_ff;
      mask_ff <= nxt_mask_ff;
      base_ff <= nxt_base_ff;
      dst_ff <= nxt_dst_ff;
      multi_ff <= nxt_multi_ff;
      wback_ff <= nxt_wback_ff;
      next_pc_ff <= nxt_next_pc_ff;
      wr_en_ff <= nxt_wr_en_ff;
      wr_idx_ff <= nxt_wr_idx_ff;
      wr_data_ff <= nxt_wr_data_ff;
      flush_ff <= nxt_flush_ff;
      retire_ff <= nxt_retire_ff;
      unpred_ff <= nxt_unpred_ff;
    end
  end
endmodule // bld_barrier_and_load_decode

// file: bld_mem_model.sv
// Memory model answering load requests after a set latency.
`timescale 1ns/10ps
module bld_mem_model (
  // Clock, reset and latency
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lat,
  // Load port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ****************************************
  // Answer
  // ****************************************
  logic [3:0] wait_ff;
  always_ff @(posedge clk) begin
    if (rst || !mem_req || mem_ack) wait_ff <= 4'h0;
    else wait_ff <= wait_ff + 4'h1;
  end
  assign mem_ack = mem_req && wait_ff == lat;
  // Data off the ack cycle is inverted, so a late sample is caught.
  assign mem_rdata = mem_ack ? mem_addr ^ 32'h5A5A5A5A : ~mem_addr;
endmodule // bld_mem_model

// file: bld_checker.sv
// Checker of the decode block's port behaviour.
`timescale 1ns/10ps
module bld_checker
  import bld_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire logic [31:0] issue_instr,
  input wire logic issue_is_wide,
  input wire logic [31:0] issue_pc,
  input wire logic cond_pass,
  input wire logic [3:0] rf_rd_idx,
  input wire logic [31:0] rf_rd_data,
  input wire logic rf_wr_en,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic ctx_ops_done,
  input wire logic pipe_flush,
  input wire logic predictor_resync,
  input wire logic retire,
  input wire logic unpredictable
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] e_imm, e_sp, e_pc;
  assign e_imm = rf_rd_data + {25'h0, issue_instr[10:6], 2'h0};
  assign e_sp = rf_rd_data + {22'h0, issue_instr[7:0], 2'h0};
  assign e_pc = ((issue_pc + 32'h4) & 32'hFFFFFFFC) + e_sp - rf_rd_data;
  sequence take(logic [4:0] code);
    issue_valid && issue_ready && !issue_is_wide && cond_pass &&
      issue_instr[15:11] == code;
  endsequence
  a_flush_resync: assert property (
    pipe_flush |-> predictor_resync && retire) else $error("flush alone");
  a_flush_ctx: assert property (
    pipe_flush |-> $past(ctx_ops_done)) else $error("flush before ctx");
  a_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request dropped");
  a_cond_quiet: assert property (
    issue_valid && issue_ready && !cond_pass |=>
      retire && !rf_wr_en && !mem_req && !pipe_flush)
    else $error("failed condition acted");
  a_sp_base: assert property (
    take(BLD_OP_LDR_SP) |-> rf_rd_idx == BLD_SP_INDEX)
    else $error("stack base wrong");
  a_sp_addr: assert property (
    take(BLD_OP_LDR_SP) |=> mem_addr == $past(e_sp)) else $error("sp addr");
  a_imm_addr: assert property (
    take(BLD_OP_LDR_IMM) |=> mem_req && mem_addr == $past(e_imm))
    else $error("imm address");
  a_pc_addr: assert property (
    take(BLD_OP_LDR_PC) |=> mem_addr == $past(e_pc)) else $error("pc addr");
  a_empty_list: assert property (
    take(BLD_OP_LDM) ##0 issue_instr[7:0] == 8'h00 |=>
      retire && unpredictable && !mem_req) else $error("empty list");
endmodule // bld_checker

bind bld_barrier_and_load_decode bld_checker u_chk (
  .clk(clk), .rst(rst), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .issue_instr(issue_instr),
  .issue_is_wide(issue_is_wide), .issue_pc(issue_pc),
  .cond_pass(cond_pass), .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data),
  .rf_wr_en(rf_wr_en), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .ctx_ops_done(ctx_ops_done), .pipe_flush(pipe_flush),
  .predictor_resync(predictor_resync), .retire(retire),
  .unpredictable(unpredictable)
);

// file: tb.sv
// Testbench of the decode block with a memory model beside it.
`timescale 1ns/10ps
module tb;
  import bld_pkg::*;
  // ****************************************
  // Harness
  // ****************************************
  logic clk, rst, issue_valid, issue_is_wide, cond_pass, ctx_ops_done;
  logic issue_ready, rf_wr_en, mem_req, mem_ack, pipe_flush, retire;
  logic predictor_resync, unpredictable;
  logic [31:0] issue_instr, issue_pc, rf_rd_data, mem_rdata, mem_addr;
  logic [31:0] rf_wr_data, refetch_pc, fpc;
  logic [3:0] rf_rd_idx, rf_wr_idx, lat;
  logic [31:0] regs [16];
  logic [35:0] wq [$];
  logic [31:0] aq [$];
  int errors, n_compared, cycles, nf, fn, unp, dly;
  assign rf_rd_data = regs[rf_rd_idx];
  bld_barrier_and_load_decode uut (.clk(clk), .rst(rst),
    .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_instr(issue_instr), .issue_is_wide(issue_is_wide),
    .issue_pc(issue_pc), .cond_pass(cond_pass), .rf_rd_idx(rf_rd_idx),
    .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en), .rf_wr_idx(rf_wr_idx),
    .rf_wr_data(rf_wr_data), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ctx_ops_done(ctx_ops_done),
    .pipe_flush(pipe_flush), .refetch_pc(refetch_pc),
    .predictor_resync(predictor_resync), .retire(retire),
    .unpredictable(unpredictable));
  bld_mem_model mem (.clk(clk), .rst(rst), .lat(lat), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Issues one instruction and gathers every port effect up to retire.
  task automatic run(input logic [31:0] ins, input logic wd, input logic cp);
    int n;
    n = 0;
    wq.delete();
    aq.delete();
    {nf, fn, unp} = 0;
    {issue_instr, issue_is_wide, cond_pass} = {ins, wd, cp};
    issue_valid = 1;
    while (issue_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    issue_valid = 0;
    do begin
      if (n > 0) @(negedge clk);
      ctx_ops_done = n >= dly;
      if (rf_wr_en === 1'b1) wq.push_back({rf_wr_idx, rf_wr_data});
      if (mem_req === 1'b1 && mem_ack === 1'b1) aq.push_back(mem_addr);
      if (pipe_flush === 1'b1) {nf, fn, fpc} = {nf + 1, n, refetch_pc};
      if (unpredictable === 1'b1) unp = 1;
      n++;
    end while (retire !== 1'b1 && n < 40);
    chk(n < 40, "no retire");
  endtask
  // Checks a single word load at address a into register d.
  task automatic one(input logic [31:0] a, input logic [3:0] d);
    chk(aq.size() == 1 && aq[0] === a, "load address");
    chk(wq.size() == 1 && wq[0] === {d, a ^ 32'h5A5A5A5A}, "load data");
  endtask
  task automatic t_ldm(input logic [2:0] b, input logic [7:0] l);
    logic [31:0] a;
    int k;
    logic wb;
    a = 32'h00003000;
    regs[b] = a;
    k = 0;
    wb = !l[b] && l != 8'h00;
    run({16'h0, BLD_OP_LDM, b, l}, 0, 1);
    for (int i = 0; i < 8; i++) begin
      if (l[i]) begin
        chk(aq[k] === a, "ldm address");
        chk(wq[k] === {i[3:0], a ^ 32'h5A5A5A5A}, "ldm data");
        a = a + 32'h4;
        k++;
      end
    end
    if (wb) chk(wq[k] === {1'b0, b, a}, "writeback");
    chk(wq.size() == k + wb && aq.size() == k, "ldm count");
    chk(unp == (l == 8'h00), "unpredictable flag");
    $display("done load multiple");
  endtask
  task automatic t_ldr_imm();
    regs[3] = 32'h00001000;
    lat = 4'h0;
    run({16'h0, BLD_OP_LDR_IMM, 5'h1F, 3'h3, 3'h5}, 0, 1);
    one(32'h0000107C, 4'h5);
    $display("done short offset load");
  endtask
  // A slow memory makes the request stand for several cycles.
  task automatic t_ldr_sp();
    regs[13] = 32'h20000000;
    lat = 4'h3;
    run({16'h0, BLD_OP_LDR_SP, 3'h6, 8'hFF}, 0, 1);
    one(32'h200003FC, 4'h6);
    $display("done stack load");
  endtask
  task automatic t_ldr_pc();
    issue_pc = 32'h00000102;
    run({16'h0, BLD_OP_LDR_PC, 3'h2, 8'h01}, 0, 1);
    one(32'h00000108, 4'h2);
    $display("done pc relative load");
  endtask
  task automatic t_cond_fail();
    run({16'h0, BLD_OP_LDR_IMM, 5'h01, 3'h3, 3'h5}, 0, 0);
    chk(wq.size() == 0 && aq.size() == 0 && nf == 0, "cond fail");
    $display("done failed condition");
  endtask
  // Encodings outside the block must retire and touch nothing.
  task automatic t_unknown();
    run(32'h00000000, 0, 1);
    chk(wq.size() == 0 && aq.size() == 0 && unp == 0, "narrow other");
    run({BLD_SYNC_HI, 16'h0000}, 1, 1);
    chk(wq.size() == 0 && aq.size() == 0 && nf == 0, "wide other");
    $display("done other encodings");
  endtask
  task automatic t_barrier();
    dly = 2;
    issue_pc = 32'h00000200;
    for (int o = 0; o < 16; o++) begin
      run({BLD_SYNC_HI, BLD_SYNC_LO_TOP, o[3:0]}, 1, 1);
      chk(nf == 1 && fn > dly && fpc === 32'h00000204, "barrier");
      chk(wq.size() == 0 && aq.size() == 0, "barrier side");
    end
    $display("done barrier options");
  endtask
  initial begin
    {rst, issue_valid, issue_is_wide, cond_pass, ctx_ops_done} = 5'h10;
    {issue_instr, issue_pc, lat, dly} = 0;
    for (int i = 0; i < 16; i++) regs[i] = 32'h00000100 * i;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_ldr_imm();
    t_ldr_sp();
    t_ldr_pc();
    lat = 4'h1;
    t_ldm(3'h1, 8'hA4);
    t_ldm(3'h2, 8'h84);
    t_ldm(3'h0, 8'hFF);
    t_ldm(3'h4, 8'h00);
    t_cond_fail();
    t_unknown();
    t_barrier();
    complete_run();
  end
endmodule // tb
